// file: rtl/wdta_cfg.svh
// register offsets, bit positions and timing constants of the watchdog block
`ifndef WDTA_CFG_SVH
`define WDTA_CFG_SVH
`define WDTA_KEY_ADDR      8'hc7
`define WDTA_WDCTL_ADDR    8'hd8
`define WDTA_CLOCK_CONTROL_REG_ADDR    8'h8e
`define WDTA_EIE_ADDR      8'he8
`define WDTA_KEY_FIRST     8'haa
`define WDTA_KEY_SECOND    8'h55
`define WDTA_WIN_CYCLES    2'h3
`define WDTA_TAIL_CLOCKS   10'h200
`define WDTA_CNT_W         26
`define WDTA_BIT_RESTART   0
`define WDTA_BIT_RST_EN    1
`define WDTA_BIT_RST_FLAG  2
`define WDTA_BIT_IRQ_FLAG  3
`define WDTA_BIT_PFI_FLAG  4
`define WDTA_BIT_PFI_EN    5
`define WDTA_BIT_POR_FLAG  6
`define WDTA_BIT_SEL_LO    6
`define WDTA_BIT_SEL_HI    7
`define WDTA_BIT_IRQ_EN    4
`define WDTA_OPT_RST_BIT   3
`define WDTA_SEL_17        2'h0
`define WDTA_SEL_20        2'h1
`define WDTA_SEL_23        2'h2
`define WDTA_SEL_26        2'h3
`define WDTA_BIT_17        16
`define WDTA_BIT_20        19
`define WDTA_BIT_23        22
`define WDTA_BIT_26        25
`endif

// file: rtl/wdta_pkg.sv
// types shared by the watchdog block
package wdta_pkg;
  typedef enum logic [1:0] {
    WDTA_KEY_IDLE = 2'h0,
    WDTA_KEY_HALF = 2'h1,
    WDTA_KEY_OPEN = 2'h3
  } wdta_key_t;
  typedef logic [7:0] wdta_byte_t;
endpackage

// file: rtl/wdta_unlock_if.sv
// unlock state carried from the key tracker to the watchdog core
`timescale 1ns/1ps
interface wdta_unlock_if;
  logic win_open;
  modport tracker (output win_open);
  modport core    (input  win_open);
endinterface

// file: rtl/wdta_unlock.sv
// timed-access key tracker opening a short protected-write window
`timescale 1ns/1ps
`include "wdta_cfg.svh"
module wdta_unlock (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              sfr_wr,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  wdta_unlock_if.tracker         ul
);
  import wdta_pkg::*;

  typedef struct packed {
    wdta_key_t  st;
    logic [1:0] win;
  } wdta_ul_state_t;

  wdta_ul_state_t cur_ff;
  wdta_ul_state_t nxt_cur;
  logic           key_wr;

  // ==========================================================
  // key sequence
  assign key_wr = sfr_wr && (sfr_addr == `WDTA_KEY_ADDR);

  always_comb begin
    nxt_cur = cur_ff;
    case (cur_ff.st)
      WDTA_KEY_IDLE: begin
        if (key_wr && sfr_wdata == `WDTA_KEY_FIRST) begin
          nxt_cur.st = WDTA_KEY_HALF;
        end
      end
      WDTA_KEY_HALF: begin
        // second key must follow at once
        if (key_wr && sfr_wdata == `WDTA_KEY_SECOND) begin
          nxt_cur.st  = WDTA_KEY_OPEN;
          nxt_cur.win = `WDTA_WIN_CYCLES;
        end else if (key_wr && sfr_wdata == `WDTA_KEY_FIRST) begin
          nxt_cur.st = WDTA_KEY_HALF;
        end else begin
          nxt_cur.st = WDTA_KEY_IDLE;
        end
      end
      WDTA_KEY_OPEN: begin
        nxt_cur.win = cur_ff.win - 2'h1;
        if (cur_ff.win == 2'h1) begin
          nxt_cur.st = WDTA_KEY_IDLE;
        end
      end
      default: nxt_cur.st = WDTA_KEY_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_ff <= '{st: WDTA_KEY_IDLE, win: 2'h0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign ul.win_open = (cur_ff.st == WDTA_KEY_OPEN);
endmodule

// file: rtl/wdta_watchdog.sv
// watchdog timer with timed-access protected control bits
`timescale 1ns/1ps
`include "wdta_cfg.svh"
// Behaviour
// - counter advances every clock, periods are exact clock multiples
// - four interrupt lengths: 2^17, 2^20, 2^23, 2^26 clocks
// - select bits 7:6 of clock control map 00..11 to 17,20,23,26
// - interrupt flag at count end, reset flag 512 clocks later
// - counter always runs; only consequences are gated
// - interrupt and reset enables are independent
// - interrupt flag is bit 3 of watchdog control
// - reset flag bit 2 set at full time-out, stays readable
// - bit 1 enables watchdog reset
// - reset enabled at a full time-out gives a CPU reset
// - writing one to bit 0 restarts a full interval
// - reset enable and restart writable only after unlock
// - keys aa then 55 open a three cycle write window
// - protected write ignored unless keys come just before
// - interrupt flag and power-on flag also protected
// - option bit 3: one disables reset at power-up, zero enables
// - interrupt request gated by enable bit 4 of ext enable reg
module wdta_watchdog (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               por_event,
  input  wire logic               pfi_event,
  input  wire logic [7:0]         option_byte,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire logic [7:0]         sfr_addr,
  input  wire wdta_pkg::wdta_byte_t sfr_wdata,
  output logic [7:0]              sfr_rdata,
  output logic                    wd_timeout_irq,
  output logic                    wd_cpu_reset
);
  import wdta_pkg::*;

  typedef struct packed {
    logic [`WDTA_CNT_W-1:0] cnt;
    logic [9:0]             tail;
    logic                   tail_run;
    logic                   strap_done;
    logic                   wd_restart;
    logic                   wd_reset_enable;
    logic                   wd_reset_flag;
    logic                   wd_irq_flag;
    logic                   pfi_flag;
    logic                   pfi_enable;
    logic                   por_flag;
    logic                   timeout_sel_hi;
    logic                   timeout_sel_lo;
    logic                   wd_irq_enable;
    logic [7:0]             rdata;
    logic                   irq;
    logic                   cpu_rst;
  } wdta_state_t;

  wdta_state_t    cur_ff;
  wdta_state_t    nxt_cur;
  wdta_unlock_if  ul ();
  logic           wr_wdctl;
  logic           wr_clock_control_reg;
  logic           wr_eie;
  logic           prot_ok;
  logic           irq_hit;
  logic [1:0]     sel;
  logic [7:0]     wdctl_view;
  logic           tail_end;

  // ==========================================================
  // timed-access key tracker
  wdta_unlock u_unlock (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .ul        (ul.tracker)
  );

  // ==========================================================
  // decode and time-out detection
  assign wr_wdctl = sfr_wr && (sfr_addr == `WDTA_WDCTL_ADDR);
  assign wr_clock_control_reg = sfr_wr && (sfr_addr == `WDTA_CLOCK_CONTROL_REG_ADDR);
  assign wr_eie   = sfr_wr && (sfr_addr == `WDTA_EIE_ADDR);
  // window only from the key tracker
  assign prot_ok  = ul.win_open;
  assign sel      = {cur_ff.timeout_sel_hi, cur_ff.timeout_sel_lo};
  // last clock of the 512-clock tail
  assign tail_end = cur_ff.tail_run &&
                    (cur_ff.tail == `WDTA_TAIL_CLOCKS - 10'h001);

  // select picks the terminal bit of the chain
  always_comb begin
    case (sel)
      `WDTA_SEL_17: irq_hit = &cur_ff.cnt[`WDTA_BIT_17:0];
      `WDTA_SEL_20: irq_hit = &cur_ff.cnt[`WDTA_BIT_20:0];
      `WDTA_SEL_23: irq_hit = &cur_ff.cnt[`WDTA_BIT_23:0];
      `WDTA_SEL_26: irq_hit = &cur_ff.cnt[`WDTA_BIT_26:0];
      default:      irq_hit = 1'b0;
    endcase
  end

  // read view of watchdog control
  always_comb begin
    wdctl_view = 8'h00;
    wdctl_view[`WDTA_BIT_RESTART]  = cur_ff.wd_restart;
    wdctl_view[`WDTA_BIT_RST_EN]   = cur_ff.wd_reset_enable;
    wdctl_view[`WDTA_BIT_RST_FLAG] = cur_ff.wd_reset_flag;
    wdctl_view[`WDTA_BIT_IRQ_FLAG] = cur_ff.wd_irq_flag;
    wdctl_view[`WDTA_BIT_PFI_FLAG] = cur_ff.pfi_flag;
    wdctl_view[`WDTA_BIT_PFI_EN]   = cur_ff.pfi_enable;
    wdctl_view[`WDTA_BIT_POR_FLAG] = cur_ff.por_flag;
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.cnt = cur_ff.cnt + `WDTA_CNT_W'(1);
    nxt_cur.wd_restart = 1'b0;   // restart bit is a self-clearing strobe

    // catch option strap once after reset release
    if (!cur_ff.strap_done) begin
      nxt_cur.strap_done = 1'b1;
      nxt_cur.wd_reset_enable = !option_byte[`WDTA_OPT_RST_BIT];
    end

    if (cur_ff.tail_run) begin
      nxt_cur.tail = cur_ff.tail + 10'h001;
      if (tail_end) begin
        nxt_cur.tail_run = 1'b0;
      end
    end

    // unprotected control writes
    if (wr_clock_control_reg) begin
      nxt_cur.timeout_sel_hi = sfr_wdata[`WDTA_BIT_SEL_HI];
      nxt_cur.timeout_sel_lo = sfr_wdata[`WDTA_BIT_SEL_LO];
    end
    if (wr_eie) begin
      nxt_cur.wd_irq_enable = sfr_wdata[`WDTA_BIT_IRQ_EN];
    end
    if (wr_wdctl) begin
      nxt_cur.pfi_enable = sfr_wdata[`WDTA_BIT_PFI_EN];
      if (!sfr_wdata[`WDTA_BIT_PFI_FLAG]) begin
        nxt_cur.pfi_flag = 1'b0;
      end
      if (!sfr_wdata[`WDTA_BIT_RST_FLAG]) begin
        nxt_cur.wd_reset_flag = 1'b0;
      end
    end

    // protected bits only inside the window
    if (wr_wdctl && prot_ok) begin
      // reset enable independent of irq enable
      nxt_cur.wd_reset_enable = sfr_wdata[`WDTA_BIT_RST_EN];
      nxt_cur.wd_irq_flag     = sfr_wdata[`WDTA_BIT_IRQ_FLAG];
      nxt_cur.por_flag        = sfr_wdata[`WDTA_BIT_POR_FLAG];
      // restart clears counter and pending tail
      if (sfr_wdata[`WDTA_BIT_RESTART]) begin
        nxt_cur.wd_restart = 1'b1;
        nxt_cur.cnt        = '0;
        nxt_cur.tail       = 10'h000;
        nxt_cur.tail_run   = 1'b0;
      end
    end

    // interrupt point; set wins over a clear, but is skipped when the same write restarts
    if (irq_hit && !(wr_wdctl && prot_ok &&
        sfr_wdata[`WDTA_BIT_RESTART])) begin
      nxt_cur.wd_irq_flag = 1'b1;
      nxt_cur.tail_run    = 1'b1;
      nxt_cur.tail        = 10'h000;
    end
    if (pfi_event) begin
      nxt_cur.pfi_flag = 1'b1;
    end
    if (por_event) begin
      nxt_cur.por_flag = 1'b1;
    end
    // reset flag set after the writes, so a set beats a clear
    if (tail_end) begin
      nxt_cur.wd_reset_flag = 1'b1;
    end

    // register reads, unmapped addresses return zero
    nxt_cur.rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        `WDTA_WDCTL_ADDR: nxt_cur.rdata = wdctl_view;
        `WDTA_CLOCK_CONTROL_REG_ADDR: begin
          nxt_cur.rdata[`WDTA_BIT_SEL_HI] = cur_ff.timeout_sel_hi;
          nxt_cur.rdata[`WDTA_BIT_SEL_LO] = cur_ff.timeout_sel_lo;
        end
        `WDTA_EIE_ADDR: begin
          nxt_cur.rdata[`WDTA_BIT_IRQ_EN] = cur_ff.wd_irq_enable;
        end
        default: nxt_cur.rdata = 8'h00;
      endcase
    end

    // interrupt request gated by its enable
    nxt_cur.irq = nxt_cur.wd_irq_flag && nxt_cur.wd_irq_enable;
    // every completed time-out resets when reset is enabled, even with a stale flag
    nxt_cur.cpu_rst = tail_end && nxt_cur.wd_reset_enable;
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign sfr_rdata      = cur_ff.rdata;
  assign wd_timeout_irq = cur_ff.irq;
  assign wd_cpu_reset   = cur_ff.cpu_rst;
endmodule

// file: tb/wdta_watchdog_sva.sv
// assertion checker bound to the watchdog block ports
`timescale 1ns/1ps
`include "wdta_cfg.svh"
module wdta_watchdog_sva
  import wdta_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire wdta_byte_t sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       wd_timeout_irq,
  input wire logic       wd_cpu_reset
);
  logic [7:0] wdata_d1_ff;
  logic [7:0] wdata_d2_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // write data delayed to line up with the read-back cycle
  always_ff @(posedge core_clk) begin
    wdata_d1_ff <= sfr_wdata;
    wdata_d2_ff <= wdata_d1_ff;
  end
  a_sel_readback: assert property (
    sfr_wr && sfr_addr == `WDTA_CLOCK_CONTROL_REG_ADDR ##1
    sfr_rd && sfr_addr == `WDTA_CLOCK_CONTROL_REG_ADDR
    |=> sfr_rdata == {wdata_d2_ff[7:6], 6'h00})
    else $error("select field readback wrong");
  a_en_readback: assert property (
    sfr_wr && sfr_addr == `WDTA_EIE_ADDR ##1
    sfr_rd && sfr_addr == `WDTA_EIE_ADDR
    |=> sfr_rdata == {3'h0, wdata_d2_ff[4], 4'h0})
    else $error("irq enable readback wrong");
  a_irq_gated_off: assert property (
    sfr_wr && sfr_addr == `WDTA_EIE_ADDR && !sfr_wdata[4]
    |-> ##2 !wd_timeout_irq)
    else $error("irq request seen while disabled");
  a_irq_held: assert property (
    wd_timeout_irq && !sfr_wr && !$past(sfr_wr) |=> wd_timeout_irq)
    else $error("irq request dropped without a write");
  a_reset_pulse: assert property (
    wd_cpu_reset |=> !wd_cpu_reset [*8])
    else $error("cpu reset longer than one pulse");
  a_flag_readable: assert property (
    wd_cpu_reset && sfr_rd && sfr_addr == `WDTA_WDCTL_ADDR && !sfr_wr
    |=> sfr_rdata[2])
    else $error("reset flag not readable");
  a_key_reads_zero: assert property (
    sfr_rd && sfr_addr == `WDTA_KEY_ADDR |=> sfr_rdata == 8'h00)
    else $error("key register returned data");
  a_quiet_release: assert property (
    $rose(rst_n) |-> !wd_cpu_reset && !wd_timeout_irq)
    else $error("outputs active at reset release");
  c_timeout: cover property ($rose(wd_timeout_irq));
  c_cpu_reset: cover property (wd_cpu_reset);
  c_second_key: cover property (sfr_wr && sfr_wdata == 8'h55);
endmodule
bind wdta_watchdog wdta_watchdog_sva u_sva (
  .core_clk       (core_clk),
  .rst_n          (rst_n),
  .sfr_wr         (sfr_wr),
  .sfr_rd         (sfr_rd),
  .sfr_addr       (sfr_addr),
  .sfr_wdata      (sfr_wdata),
  .sfr_rdata      (sfr_rdata),
  .wd_timeout_irq (wd_timeout_irq),
  .wd_cpu_reset   (wd_cpu_reset)
);

// file: tb/wdta_cpu_model.sv
// cpu-side model issuing special function register accesses
`timescale 1ns/1ps
`include "wdta_cfg.svh"
module wdta_cpu_model
  import wdta_pkg::*;
(
  input  wire logic       core_clk,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic [7:0]      sfr_addr,
  output wdta_byte_t      sfr_wdata,
  input  wire logic [7:0] sfr_rdata
);
  // bus quiet at time zero
  initial begin
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
  end
  // one write, taken at the next edge; strobe stays up for back-to-back
  task automatic wr(input logic [7:0] a, input wdta_byte_t v);
    sfr_rd <= 1'b0;
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= v;
    @(posedge core_clk);
    #1;
  endtask
  // read data stands for the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge core_clk);
    #1;
    v = sfr_rdata;
  endtask
  task automatic idle(input int n);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic unlock();
    wr(`WDTA_KEY_ADDR, `WDTA_KEY_FIRST);
    wr(`WDTA_KEY_ADDR, `WDTA_KEY_SECOND);
  endtask
  task automatic kick(input logic [7:0] keep);
    unlock();
    wr(`WDTA_WDCTL_ADDR, keep | 8'h01);
    idle(0);
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the timed-access watchdog
`timescale 1ns/1ps
`include "wdta_cfg.svh"
module testbench;
  import wdta_pkg::*;
  localparam logic [7:0] WDC = `WDTA_WDCTL_ADDR;
  localparam logic [7:0] CKC = `WDTA_CLOCK_CONTROL_REG_ADDR;
  localparam logic [7:0] EXT_IRQ_ENABLE_REG = `WDTA_EIE_ADDR;
  logic       core_clk = 1'b0;
  logic       rst_n;
  logic       por_event;
  logic       pfi_event;
  logic [7:0] option_byte;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  wdta_byte_t sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       wd_timeout_irq;
  logic       wd_cpu_reset;
  logic [7:0] d;
  logic [7:0] r;
  int         seed;
  int         n;
  int         err_count = 0;
  int         n_checks = 0;
  always #50 core_clk = ~core_clk;
  wdta_cpu_model u_cpu (.core_clk(core_clk), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));
  wdta_watchdog u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .por_event(por_event), .pfi_event(pfi_event),
    .option_byte(option_byte), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .wd_timeout_irq(wd_timeout_irq), .wd_cpu_reset(wd_cpu_reset));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait for the request or the reset pulse
  task automatic wait_out(input logic use_rst, input int lim);
    n = 0;
    while ((use_rst ? wd_cpu_reset : wd_timeout_irq) !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > lim) begin
        err_count++;
        end_of_test();
      end
    end
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // interrupt time-out length in clocks for a select code
  function automatic logic [31:0] irq_clocks(input logic [1:0] s);
    irq_clocks = 32'h1 << (6'd17 + 6'd3 * {4'h0, s});
  endfunction
  // main sequence
  initial begin
    seed = 43;
    por_event <= 1'b0;
    pfi_event <= 1'b0;
    // random strap with the reset-disable bit 3 clear
    option_byte <= 8'($random(seed)) & 8'hf7;
    do_reset();
    u_cpu.rd(WDC, d);
    check(d & 8'h0a, 8'h02);
    u_cpu.wr(WDC, 8'h00);
    u_cpu.rd(WDC, d);
    check(d & 8'h02, 8'h02);
    // key pair split by another write
    u_cpu.wr(`WDTA_KEY_ADDR, `WDTA_KEY_FIRST);
    u_cpu.wr(WDC, 8'h00);
    u_cpu.wr(`WDTA_KEY_ADDR, `WDTA_KEY_SECOND);
    u_cpu.wr(WDC, 8'h00);
    u_cpu.rd(WDC, d);
    check(d & 8'h02, 8'h02);
    // first cycle after the window is shut
    u_cpu.unlock();
    u_cpu.idle(3);
    u_cpu.wr(WDC, 8'h00);
    u_cpu.rd(WDC, d);
    check(d & 8'h02, 8'h02);
    // last open cycle of the window
    u_cpu.unlock();
    u_cpu.idle(2);
    u_cpu.wr(WDC, 8'h00);
    u_cpu.rd(WDC, d);
    check(d & 8'h02, 8'h00);
    u_cpu.rd(`WDTA_KEY_ADDR, d);
    check(d, 8'h00);
    // every select code, random data, unprotected control writes
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      r[7:6] = i[1:0];
      u_cpu.wr(CKC, r);
      u_cpu.rd(CKC, d);
      check(d, {r[7:6], 6'h00});
      u_cpu.wr(WDC, r);
      u_cpu.rd(WDC, d);
      check(d & 8'h0b, 8'h00);
    end
    // power-on flag needs the window, power-fail flag does not
    por_event <= 1'b1;
    pfi_event <= 1'b1;
    @(posedge core_clk);
    por_event <= 1'b0;
    pfi_event <= 1'b0;
    u_cpu.wr(WDC, 8'h00);
    u_cpu.rd(WDC, d);
    check(d & 8'h50, 8'h40);
    u_cpu.kick(8'h00);
    u_cpu.rd(WDC, d);
    check(d & 8'h40, 8'h00);
    // shortest time-out, irq and reset both enabled
    u_cpu.wr(CKC, 8'h00);
    u_cpu.wr(EXT_IRQ_ENABLE_REG, 8'h10);
    u_cpu.kick(8'h02);
    wait_out(1'b0, 140000);
    check(n, irq_clocks(`WDTA_SEL_17));
    wait_out(1'b1, 600);
    check(n, {22'h0, `WDTA_TAIL_CLOCKS});
    u_cpu.rd(WDC, d);
    check(d & 8'h0e, 8'h0e);
    // restart keeps the flag; the enable alone hides the request
    u_cpu.kick(8'h0a);
    u_cpu.wr(EXT_IRQ_ENABLE_REG, 8'h00);
    u_cpu.rd(EXT_IRQ_ENABLE_REG, d);
    u_cpu.idle(2);
    check({d, wd_timeout_irq}, 9'h000);
    u_cpu.rd(WDC, d);
    check(d & 8'h08, 8'h08);
    u_cpu.wr(EXT_IRQ_ENABLE_REG, 8'h10);
    u_cpu.idle(2);
    check(wd_timeout_irq, 1'b1);
    u_cpu.kick(8'h02);
    u_cpu.idle(2);
    check(wd_timeout_irq, 1'b0);
    option_byte <= 8'($random(seed)) | 8'h08;
    do_reset();
    u_cpu.rd(WDC, d);
    check(d & 8'h02, 8'h00);
    end_of_test();
  end
endmodule
